/* File: logic/dtq_consts.vh */
// constants for the debug trigger qualifier: offsets, fields, reset values
// assumes inclusion by bare name from the design file
`ifndef DTQ_CONSTS_VH
`define DTQ_CONSTS_VH
// register offsets on the plain register port
`define DTQ_OFF_CTRL      4'h0
`define DTQ_OFF_TRIG      4'h1
`define DTQ_OFF_CMPA_HI   4'h2
`define DTQ_OFF_CMPA_LO   4'h3
`define DTQ_OFF_CMPB_HI   4'h4
`define DTQ_OFF_CMPB_LO   4'h5
`define DTQ_OFF_STATUS    4'h6
// debug_control fields
`define DTQ_CTL_EN        7
`define DTQ_CTL_ARM       6
`define DTQ_CTL_A_DIR     3
`define DTQ_CTL_A_DIREN   2
`define DTQ_CTL_B_DIR     1
`define DTQ_CTL_B_DIREN   0
// debug_trigger_config fields
`define DTQ_TRG_TAG       7
`define DTQ_TRG_BEGIN     6
`define DTQ_TRG_WMASK     8'hcf
// trigger mode codes
`define DTQ_M_A_ONLY      4'h0
`define DTQ_M_A_OR_B      4'h1
`define DTQ_M_A_THEN_B    4'h2
`define DTQ_M_EVT_B       4'h3
`define DTQ_M_A_THEN_EVT  4'h4
`define DTQ_M_A_AND_BD    4'h5
`define DTQ_M_A_NOT_BD    4'h6
`define DTQ_M_INSIDE      4'h7
`define DTQ_M_OUTSIDE     4'h8
// reset values
`define DTQ_RST_CTRL      8'h00
`define DTQ_RST_TRIG      8'h00
`define DTQ_RST_CMP       16'h0000
`endif

/* File: logic/dtq_trigger.v */
// debug trigger qualifier: comparators, mode select, trace start/stop
// assumes one bus clock, cpu bus inputs synchronous, fifo logic outside
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dtq_consts.vh"

// overview of the block
// - two 16-bit comparators watch every cpu bus cycle
// - each comparator may be qualified by bus direction
// - a mode code picks how the two hits combine
// - force type: a bus hit is the event itself
// - tag type, modes 0-6: a hit marks a fetch, execution is the event
// - end trace: capture runs circularly until the trigger
// - begin trace: capture starts at the trigger
// - event-only modes store one byte per b event
//
// register port
// - one write strobe and one read strobe, never together
// - read data is registered and stands one cycle only
// - idle cycles read back as zero, so a stale byte
//   can never be mistaken for a fresh one
//
// hazards worth knowing
// - compare values and trigger config freeze while armed;
//   software must disarm before changing them
// - the control byte stays writable so a run can be
//   stopped at any time by clearing enable or arm
// - a run that completes in the same cycle as a control
//   write wins, unless that write newly arms the block
// - the fifo itself lives outside; only strobes leave
//   this block, so the fifo depth is not known here
// - begin trace runs end only on fifo_full; with a fifo
//   that never fills, the run lasts until software stops it
//
// timing
// - every output is a flip-flop; trig_pulse and store_en
//   refer to the bus cycle one clock earlier
// - armed follows the next value of the arm bit, so it
//   falls in the same cycle as the ending trig_pulse

// Summary of operation
// - dir enable a set: write/read per dir bit
// - dir enable a clear: direction ignored
// - dir enable b set: write/read per dir bit
// - dir enable b clear: direction ignored
// - trigger config writable only while disarmed
// - config bits 4,5 read zero
// - tag clear: trigger on access
// - tag set: modes 0-6 trigger only when opcode executes; range modes 7-8 ignore tag
// - begin clear: circular store, trigger ends
// - begin set: store starts at trigger
// - event-only modes always begin trace
// - modes 0-2: a, a or b, a then b
// - modes 3-4: store on b events
// - modes 5-6: address a with data b, address a without data b
// - modes 7-8: inside or outside range
// - modes 9-15 never trigger
// - arm write sets flag; run end clears
// - event-only modes store low byte only
module dtq_trigger (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // cpu bus
    input  wire        bus_valid,
    input  wire [15:0] bus_addr,
    input  wire [7:0]  bus_data,
    input  wire        bus_read,
    // opcode tracking
    input  wire        op_exec,
    input  wire [15:0] op_addr,
    // fifo side
    input  wire        fifo_full,
    output reg         trig_pulse,
    output reg         store_en,
    output reg         store_byte_only,
    output reg         armed
);

    // configuration state
    reg  [7:0]  ctrl_r;          // debug_control
    reg  [7:0]  trig_r;          // debug_trigger_config
    reg  [15:0] cmpa_r;          // comparator a value
    reg  [15:0] cmpb_r;          // comparator b value
    reg         a_seen_r;        // a matched since arming
    reg         b_seen_r;        // b matched since arming
    reg         tag_a_r;         // tagged opcode address pending for a
    reg         tag_b_r;         // tagged opcode address pending for b
    reg  [15:0] tag_a_addr_r;    // address of tagged a fetch
    reg  [15:0] tag_b_addr_r;    // address of tagged b fetch
    reg         storing_r;       // capture running

    // direction qualifier shared by both comparators
    function dir_ok;
        input en;
        input dir;
        input rd;
        begin
            dir_ok = ~en | (dir == rd);
        end
    endfunction

    wire [3:0] mode   = trig_r[3:0];
    wire       tagm   = trig_r[`DTQ_TRG_TAG];
    wire       arm_on = ctrl_r[`DTQ_CTL_ARM];
    wire       evt_mode = (mode == `DTQ_M_EVT_B) |
                          (mode == `DTQ_M_A_THEN_EVT);
    wire       begin_tr = trig_r[`DTQ_TRG_BEGIN] | evt_mode;

    // raw comparator hits, every bus cycle
    wire qa = dir_ok(ctrl_r[`DTQ_CTL_A_DIREN], ctrl_r[`DTQ_CTL_A_DIR],
                     bus_read);
    wire qb = dir_ok(ctrl_r[`DTQ_CTL_B_DIREN], ctrl_r[`DTQ_CTL_B_DIR],
                     bus_read);
    wire hit_a   = bus_valid & qa & (bus_addr == cmpa_r);
    wire hit_b   = bus_valid & qb & (bus_addr == cmpb_r);
    wire hit_bd  = bus_valid & qb & (bus_data == cmpb_r[7:0]);
    wire in_rng  = bus_valid & qa & (bus_addr >= cmpa_r) &
                   (bus_addr <= cmpb_r);
    wire out_rng = bus_valid & qa & ((bus_addr < cmpa_r) |
                   (bus_addr > cmpb_r));

    // tag path: a hit only counts once its opcode executes
    // one pending fetch per comparator; a later hit simply
    // overwrites the remembered address (limitation: two
    // fetches in flight at once cannot both be tracked)
    wire exe_a = op_exec & tag_a_r & (op_addr == tag_a_addr_r);
    wire exe_b = op_exec & tag_b_r & (op_addr == tag_b_addr_r);
    wire ev_a  = tagm ? exe_a : hit_a;
    wire ev_b  = tagm ? exe_b : hit_b;
    wire a_any = a_seen_r | ev_a;

    // mode decode
    // codes above the outside-range mode fall to the default
    // branch and never trigger, whatever the comparators say
    reg trig_c;
    always @* begin
        case (mode)
            `DTQ_M_A_ONLY:     trig_c = ev_a;
            `DTQ_M_A_OR_B:     trig_c = ev_a | ev_b;
            `DTQ_M_A_THEN_B:   trig_c = a_seen_r & ev_b;
            `DTQ_M_EVT_B:      trig_c = ev_b;
            `DTQ_M_A_THEN_EVT: trig_c = a_seen_r & ev_b;
            `DTQ_M_A_AND_BD:   trig_c = ev_a & hit_bd;
            `DTQ_M_A_NOT_BD:   trig_c = ev_a & ~hit_bd;
            `DTQ_M_INSIDE:     trig_c = in_rng;
            `DTQ_M_OUTSIDE:    trig_c = out_rng;
            default:           trig_c = 1'b0;
        endcase
    end

    wire trig_arm = arm_on & trig_c;
    // run ends: end trace on trigger, begin trace on full fifo
    wire run_done = arm_on & (begin_tr ? (storing_r & fifo_full)
                                       : trig_c);
    wire wr_ctrl  = reg_wr & (reg_addr == `DTQ_OFF_CTRL);
    wire arm_set  = wr_ctrl & reg_wdata[`DTQ_CTL_ARM] &
                    reg_wdata[`DTQ_CTL_EN] & ~arm_on;
    // next value of the arm bit, mirrored onto the armed pin
    // so that the pin does not lag the run end by a cycle
    wire arm_wval = reg_wdata[`DTQ_CTL_ARM] & reg_wdata[`DTQ_CTL_EN];
    wire arm_nxt  = (run_done & ~arm_set) ? 1'b0 :
                    (wr_ctrl ? arm_wval : arm_on);

    // registers and run state
    // one process owns all configuration so that a write and
    // a run end in the same cycle resolve in a single place
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_r       <= `DTQ_RST_CTRL;
            trig_r       <= `DTQ_RST_TRIG;
            cmpa_r       <= `DTQ_RST_CMP;
            cmpb_r       <= `DTQ_RST_CMP;
            a_seen_r     <= 1'b0;
            b_seen_r     <= 1'b0;
            tag_a_r      <= 1'b0;
            tag_b_r      <= 1'b0;
            tag_a_addr_r <= `DTQ_RST_CMP;
            tag_b_addr_r <= `DTQ_RST_CMP;
            storing_r    <= 1'b0;
        end else begin
            // control always writable; run completion wins over writes that do not newly arm
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata;
                if (~reg_wdata[`DTQ_CTL_EN])
                    ctrl_r[`DTQ_CTL_ARM] <= 1'b0;
            end
            if (run_done & ~arm_set)
                ctrl_r[`DTQ_CTL_ARM] <= 1'b0;
            // compare values and config frozen while armed
            if (reg_wr & ~arm_on) begin
                case (reg_addr)
                    `DTQ_OFF_TRIG:
                        trig_r <= reg_wdata & `DTQ_TRG_WMASK;
                    `DTQ_OFF_CMPA_HI: cmpa_r[15:8] <= reg_wdata;
                    `DTQ_OFF_CMPA_LO: cmpa_r[7:0]  <= reg_wdata;
                    `DTQ_OFF_CMPB_HI: cmpb_r[15:8] <= reg_wdata;
                    `DTQ_OFF_CMPB_LO: cmpb_r[7:0]  <= reg_wdata;
                    default: ;
                endcase
            end
            // tag capture: remember fetch addresses that hit
            if (hit_a)
                tag_a_addr_r <= bus_addr;
            if (hit_b)
                tag_b_addr_r <= bus_addr;
            tag_a_r <= arm_on & tagm & (hit_a | (tag_a_r & ~exe_a));
            tag_b_r <= arm_on & tagm & (hit_b | (tag_b_r & ~exe_b));
            // match memory, cleared at the start of a run
            if (arm_set) begin
                a_seen_r  <= 1'b0;
                b_seen_r  <= 1'b0;
                storing_r <= ~trig_r[`DTQ_TRG_BEGIN] &
                             ~((trig_r[3:0] == `DTQ_M_EVT_B) |
                               (trig_r[3:0] == `DTQ_M_A_THEN_EVT));
            end else if (arm_on) begin
                if (ev_a)
                    a_seen_r <= 1'b1;
                if (ev_b)
                    b_seen_r <= 1'b1;
                if (begin_tr & trig_arm)
                    storing_r <= 1'b1;
                if (run_done)
                    storing_r <= 1'b0;
            end else begin
                storing_r <= 1'b0;
            end
        end
    end

    // outputs, all registered
    // store_en is gated by the arm bit: a manual stop must
    // not let one stale store slip out after disarming
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata       <= 8'h00;
            trig_pulse      <= 1'b0;
            store_en        <= 1'b0;
            store_byte_only <= 1'b0;
            armed           <= 1'b0;
        end else begin
            trig_pulse <= trig_arm;
            // event modes store each qualifying b event only
            store_en <= arm_on & (evt_mode ? (trig_arm & (a_any |
                        (mode == `DTQ_M_EVT_B)))
                        : (storing_r & ~run_done) |
                          (begin_tr & trig_arm));
            store_byte_only <= evt_mode;
            armed <= arm_nxt;
            // read mux; unmapped reads return zero
            if (reg_rd) begin
                case (reg_addr)
                    `DTQ_OFF_CTRL:    reg_rdata <= ctrl_r;
                    `DTQ_OFF_TRIG:    reg_rdata <= trig_r;
                    `DTQ_OFF_CMPA_HI: reg_rdata <= cmpa_r[15:8];
                    `DTQ_OFF_CMPA_LO: reg_rdata <= cmpa_r[7:0];
                    `DTQ_OFF_CMPB_HI: reg_rdata <= cmpb_r[15:8];
                    `DTQ_OFF_CMPB_LO: reg_rdata <= cmpb_r[7:0];
                    `DTQ_OFF_STATUS:  reg_rdata <= {a_seen_r, b_seen_r,
                                          arm_on, storing_r, 4'h0};
                    default:          reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule // dtq_trigger
`default_nettype wire

/* File: testbench/dtq_trigger_properties.sv */
// port-level checks for the debug trigger qualifier
// assumes one clock clk_sys and synchronous active high sys_rst
`timescale 1ns/1ps
`default_nettype none
`include "dtq_consts.vh"
module dtq_trigger_props (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // bus activity and results
    input wire logic       bus_valid,
    input wire logic       op_exec,
    input wire logic       trig_pulse,
    input wire logic       store_en,
    input wire logic       armed
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // read of the trigger config byte
    sequence s_cfg_read;
        reg_rd && reg_addr == `DTQ_OFF_TRIG;
    endsequence
    // write that enables and arms together
    sequence s_arm_write;
        reg_wr && reg_addr == `DTQ_OFF_CTRL && reg_wdata[7:6] == 2'b11;
    endsequence
    a_cfg_bits_zero: assert property (s_cfg_read |=> reg_rdata[5:4] == 2'b00)
        else $error("config bits 5:4 read nonzero");
    a_rdata_cause: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data without a read");
    a_rdata_once: assert property (reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data held too long");
    a_arm_set: assert property (s_arm_write && !armed |=> armed)
        else $error("arm write did not arm");
    a_arm_cause: assert property ($rose(armed) |-> $past(reg_wr))
        else $error("armed rose without a write");
    a_disarm_write: assert property (reg_wr && reg_addr == `DTQ_OFF_CTRL && !reg_wdata[7] |=> !armed)
        else $error("disable write left block armed");
    a_trig_armed: assert property (trig_pulse |-> $past(armed))
        else $error("trigger while disarmed");
    a_trig_cause: assert property (trig_pulse |-> $past(bus_valid || op_exec))
        else $error("trigger without bus activity");
    a_store_armed: assert property (store_en |-> $past(armed))
        else $error("store while disarmed");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !armed && !trig_pulse && !store_en)
        else $error("outputs active after reset");
endmodule // dtq_trigger_props
bind dtq_trigger dtq_trigger_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_valid(bus_valid), .op_exec(op_exec),
    .trig_pulse(trig_pulse), .store_en(store_en), .armed(armed));
`default_nettype wire

/* File: testbench/dtq_cpu_model.sv */
// stand-in for the cpu bus and opcode tracking
// assumes the bench calls access once per clock for back-to-back cycles
`timescale 1ns/1ps
`default_nettype none
module dtq_cpu_model (
    // clock
    input  wire logic        clk_sys,
    // cpu bus cycle
    output var  logic        bus_valid,
    output var  logic [15:0] bus_addr,
    output var  logic [7:0]  bus_data,
    output var  logic        bus_read,
    // opcode execution
    output var  logic        op_exec,
    output var  logic [15:0] op_addr
);
    // idle bus at time zero
    initial begin
        {bus_valid, bus_read, op_exec} = 3'b000;
        {bus_addr, bus_data, op_addr} = 40'h0;
    end
    // one bus or execute cycle, launched just after a rising edge
    task automatic access(input logic v, op, input logic [15:0] a,
                          input logic [7:0] d, input logic r);
        @(posedge clk_sys);
        bus_valid <= v;
        op_exec   <= op;
        // released lines flip so a stale value never looks valid
        bus_addr  <= v ? a : ~bus_addr;
        bus_data  <= v ? d : ~bus_data;
        bus_read  <= v ? r : ~bus_read;
        op_addr   <= op ? a : ~op_addr;
    endtask
endmodule // dtq_cpu_model
`default_nettype wire

/* File: testbench/tb_debug_trigger_qualifier.sv */
// self-checking bench for the debug trigger qualifier
// assumes the cpu stand-in model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "dtq_consts.vh"
module tb_debug_trigger_qualifier;
    logic        clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic [3:0]  reg_addr = 0;
    logic [7:0]  reg_wdata = 0;
    logic        fifo_full = 0;  // never full: only end-trace runs end by trigger, begin-trace runs end by software
    wire  [7:0]  reg_rdata, bus_data;
    wire  [15:0] bus_addr, op_addr;
    wire         bus_valid, bus_read, op_exec, trig_pulse, store_en;
    wire         store_byte_only, armed;
    int          err_total = 0, comparisons = 0;
    logic [31:0] seed = 32'h2718;  // xorshift state
    logic [15:0] ca, cb;           // model compare values
    logic [7:0]  ctl;              // model control byte
    logic [3:0]  md;               // model mode
    logic        beg, tg, ev, m_armed, m_seen, m_trig, m_tagd, e_hit;
    dtq_trigger dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read),
        .op_exec(op_exec), .op_addr(op_addr), .fifo_full(fifo_full),
        .trig_pulse(trig_pulse), .store_en(store_en),
        .store_byte_only(store_byte_only), .armed(armed));
    dtq_cpu_model cpu (.clk_sys(clk_sys), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read),
        .op_exec(op_exec), .op_addr(op_addr));
    initial forever #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(string what, logic [15:0] e, logic [15:0] got);
        comparisons++;
        if (got !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 0;
        @(negedge clk_sys);
        chk("reg_rdata", e, reg_rdata);
    endtask
    // launch one cycle, check the previous one, then model this one
    task automatic step(input logic v, op, input logic [15:0] a,
                        input logic [7:0] d, input logic r);
        logic ma, mb, bd, rg, hit;
        cpu.access(v, op, a, d, r);
        @(negedge clk_sys);
        if (ev) chk("store_en", e_hit, store_en);
        else chk("trig_pulse", e_hit, trig_pulse);
        if (!ev && beg && !m_trig) chk("store_en", 0, store_en);
        chk("armed", m_armed, armed);
        ma = v && a == ca && (!ctl[2] || r == ctl[3]);
        mb = v && a == cb && (!ctl[0] || r == ctl[1]);
        bd = d == cb[7:0] && (!ctl[0] || r == ctl[1]);
        rg = v && (!ctl[2] || r == ctl[3]);
        case (md)
            4'h0: hit = ma;
            4'h1: hit = ma || mb;
            4'h2, 4'h4: hit = m_seen && mb;
            4'h3: hit = mb;
            4'h5: hit = ma && bd;
            4'h6: hit = ma && !bd;
            4'h7: hit = rg && a >= ca && a <= cb;
            4'h8: hit = rg && (a < ca || a > cb);
            default: hit = 0;
        endcase
        if (tg) hit = op && a == ca && m_tagd;
        if (op && a == ca) m_tagd = 0; // executed tag is consumed
        m_tagd |= ma && m_armed;
        e_hit = hit && m_armed;
        m_seen |= ma && m_armed;
        m_trig |= e_hit;
        if (e_hit && !ev && !beg) m_armed = 0;
    endtask
    // one armed run with random compares, directions and begin bit
    task automatic run(input logic [3:0] m, input logic t);
        logic [7:0]  trg;
        logic [15:0] a;
        {md, tg, ev} = {m, t, m == 4'h3 || m == 4'h4};
        seed = xs(seed);
        beg = seed[8];
        ca = 16'h2000 + seed[7:0];
        cb = ca + 16'h0100;
        ctl = {4'hc, t ? 2'b11 : seed[11:10], seed[13:12]};
        trg = {t, beg, 2'b11, m};
        wr(`DTQ_OFF_TRIG, trg);
        rd(`DTQ_OFF_TRIG, trg & `DTQ_TRG_WMASK);
        wr(`DTQ_OFF_CMPA_HI, ca[15:8]);
        wr(`DTQ_OFF_CMPA_LO, ca[7:0]);
        wr(`DTQ_OFF_CMPB_HI, cb[15:8]);
        wr(`DTQ_OFF_CMPB_LO, cb[7:0]);
        wr(`DTQ_OFF_CTRL, ctl);
        {m_armed, m_seen, m_trig, m_tagd, e_hit} = 5'b10000;
        wr(`DTQ_OFF_TRIG, ~trg);
        wr(`DTQ_OFF_CMPA_LO, ~ca[7:0]);
        for (int i = 0; i < 14; i++) begin
            seed = xs(seed);
            case (seed[2:0])
                0, 1: a = ca;
                2, 3: a = cb;
                4: a = ca - 1;
                5: a = cb + 1;
                default: a = ca + seed[23:16];
            endcase
            step(!(t && seed[3]), t && seed[3], a,
                 seed[4] ? cb[7:0] : seed[31:24], seed[5]);
        end
        step(0, 0, ca, 8'h00, 0);
        chk("store_byte_only", ev, store_byte_only);
        rd(`DTQ_OFF_TRIG, trg & `DTQ_TRG_WMASK);
        rd(`DTQ_OFF_CMPA_LO, ca[7:0]);
        wr(`DTQ_OFF_CTRL, 8'h00);
        $display("run mode %0d tag %0d done", m, t);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 0;
        for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
        for (int i = 0; i < 32; i++) run(i[3:0], 0);
        repeat (4) run(4'h0, 1);
        results();
    end
    // hang guard: about seven times the expected run length
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule // tb_debug_trigger_qualifier
`default_nettype wire
